/* File: rtl/byte_alu_bit_ops.sv */
// Byte ALU for add, AND and single-bit operations of an 8-bit core.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module byte_alu_bit_ops
  import byte_alu_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Software register port
  input  wire logic [3:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  output logic      [7:0] bus_rdata,
  // Instruction issue
  input  wire logic       instr_valid,
  input  wire instr_t     instr,
  output logic            instr_ready,
  output logic            instr_done,
  // File register port
  output file_req_t       file_req,
  input  wire logic [7:0] file_rd_data,
  // I/O port pin levels
  input  wire logic [7:0] port_pins,
  // Status flags
  output logic            carry_flag,
  output logic            digit_carry_flag,
  output logic            zero_flag
);

  instr_t     instr_reg;
  logic [7:0] working_reg;
  logic [7:0] working_next;
  logic [2:0] flags_reg;
  logic [2:0] flags_next;
  logic [7:0] operand_reg;
  logic [7:0] result_reg;
  logic [7:0] result_next;
  logic [2:0] alu_flags_reg;
  logic [2:0] alu_flags_next;
  logic [7:0] retired_reg;
  logic [7:0] rdata_reg;
  logic [7:0] pins_meta_reg;
  logic [7:0] pins_sync_reg;

  logic       take;
  logic       active;
  logic [1:0] phase;
  logic       last;

  // The pins are asynchronous; only the second stage is read by logic.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins_meta_reg <= 8'h00;
      pins_sync_reg <= 8'h00;
    end else begin
      pins_meta_reg <= port_pins;
      pins_sync_reg <= pins_meta_reg;
    end
  end

  // Issue accepts a new instruction also in the commit period, so that
  // instructions follow each other with no idle period.
  assign instr_ready = !active || last;
  assign take        = instr_valid && instr_ready;

  phase_counter #(
    .PHASES (OSC_PER_INSTR)
  ) u_phase (
    .clk    (clk),
    .rst    (rst),
    .start  (take),
    .active (active),
    .phase  (phase),
    .last   (last)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_reg <= '0;
    end else if (take) begin
      instr_reg <= instr;
    end
  end

  // Operation decode.
  wire is_add_lit  = instr_reg.op == OP_ADD_LITERAL_TO_WORKING;
  wire is_and_lit  = instr_reg.op == OP_AND_LITERAL_WITH_WORKING;
  wire is_add_file = instr_reg.op == OP_ADD_WORKING_TO_FILE;
  wire is_and_file = instr_reg.op == OP_AND_WORKING_WITH_FILE;
  wire is_bit_clr  = instr_reg.op == OP_BIT_CLEAR_IN_FILE;
  wire is_bit_set  = instr_reg.op == OP_BIT_SET_IN_FILE;
  wire is_literal  = is_add_lit || is_and_lit;
  wire is_add      = is_add_lit || is_add_file;
  wire is_and      = is_and_lit || is_and_file;
  wire is_bit_op   = is_bit_clr || is_bit_set;
  wire to_file     = is_bit_op || ((is_add_file || is_and_file) && instr_reg.dest_file);
  wire to_working  = is_literal || ((is_add_file || is_and_file) && !instr_reg.dest_file);
  wire at_port     = instr_reg.file_addr == PORT_FILE_ADDR;
  wire in_read     = active && (phase == PH_READ);
  wire in_fetch    = active && (phase == PH_FETCH);
  wire in_exec     = active && (phase == PH_EXEC);
  wire commit      = last;

  // Operand source: literal, pin levels for the port register, else file data.
  wire [7:0] operand_next = is_literal ? instr_reg.literal :
                            at_port    ? pins_sync_reg :
                                         file_rd_data;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      operand_reg <= 8'h00;
    end else if (in_fetch) begin
      operand_reg <= operand_next;
    end
  end

  logic [7:0] add_sum;
  logic       add_carry;
  logic       add_nibble;

  byte_adder #(
    .WIDTH (DATA_W)
  ) u_adder (
    .a            (working_reg),
    .b            (operand_reg),
    .sum          (add_sum),
    .carry_out    (add_carry),
    .nibble_carry (add_nibble)
  );

  wire [7:0] bit_mask = 8'h01 << instr_reg.bit_idx;
  wire [7:0] and_val  = working_reg & operand_reg;
  wire [7:0] clr_val  = operand_reg & ~bit_mask;
  wire [7:0] set_val  = operand_reg | bit_mask;

  assign result_next = is_add     ? add_sum :
                       is_and     ? and_val :
                       is_bit_clr ? clr_val :
                                    set_val;

  // Carry flags only follow additions; Z follows additions and ANDs.
  assign alu_flags_next[FLAG_CARRY] = add_carry;
  assign alu_flags_next[FLAG_DIGIT] = add_nibble;
  assign alu_flags_next[FLAG_ZERO]  = result_next == 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_reg    <= 8'h00;
      alu_flags_reg <= FLAGS_RESET;
    end else if (in_exec) begin
      result_reg    <= result_next;
      alu_flags_reg <= alu_flags_next;
    end
  end

  // File port: read in the first period, write back in the last.
  assign file_req.rd_en   = in_read && !is_literal;
  assign file_req.wr_en   = commit && to_file;
  assign file_req.addr    = instr_reg.file_addr;
  assign file_req.wr_data = result_reg;

  // Software writes to working and flags land unless the instruction commits the same state; retired ignores writes.
  wire sw_wr_working = bus_wr && (bus_addr == REG_WORKING);
  wire sw_wr_flags   = bus_wr && (bus_addr == REG_FLAGS);
  wire alu_wr_work   = commit && to_working;
  wire alu_wr_carry  = commit && is_add;
  wire alu_wr_zero   = commit && (is_add || is_and);

  assign working_next = alu_wr_work   ? result_reg :
                        sw_wr_working ? bus_wdata  :
                                        working_reg;

  assign flags_next[FLAG_CARRY] = alu_wr_carry ? alu_flags_reg[FLAG_CARRY] :
                                  sw_wr_flags  ? bus_wdata[FLAG_CARRY] :
                                                 flags_reg[FLAG_CARRY];
  assign flags_next[FLAG_DIGIT] = alu_wr_carry ? alu_flags_reg[FLAG_DIGIT] :
                                  sw_wr_flags  ? bus_wdata[FLAG_DIGIT] :
                                                 flags_reg[FLAG_DIGIT];
  assign flags_next[FLAG_ZERO]  = alu_wr_zero  ? alu_flags_reg[FLAG_ZERO] :
                                  sw_wr_flags  ? bus_wdata[FLAG_ZERO] :
                                                 flags_reg[FLAG_ZERO];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      working_reg <= WORKING_RESET;
      flags_reg   <= FLAGS_RESET;
      retired_reg <= RETIRED_RESET;
    end else begin
      working_reg <= working_next;
      flags_reg   <= flags_next;
      retired_reg <= commit ? retired_reg + 8'h01 : retired_reg;
    end
  end

  assign instr_done       = commit;
  assign carry_flag       = flags_reg[FLAG_CARRY];
  assign digit_carry_flag = flags_reg[FLAG_DIGIT];
  assign zero_flag        = flags_reg[FLAG_ZERO];

  // Read data stand in the cycle after the strobe; unmapped offsets read zero.
  wire [7:0] rd_mux = (bus_addr == REG_WORKING) ? working_reg :
                      (bus_addr == REG_FLAGS)   ? {5'h00, flags_reg} :
                      (bus_addr == REG_RETIRED) ? retired_reg :
                                                  8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= bus_rd ? rd_mux : 8'h00;
    end
  end

  assign bus_rdata = rdata_reg;

  // Checks.
  chk_lit_add_sum: assert property (
    @(posedge clk) disable iff (rst)
    (commit && is_add_lit && !sw_wr_working) |=>
      working_reg == 8'($past(working_reg) + $past(instr_reg.literal)))
    else $error("literal add wrote a wrong sum");

  chk_lit_and_carries: assert property (
    @(posedge clk) disable iff (rst)
    (commit && is_and_lit && !sw_wr_flags) |=>
      $stable(carry_flag) && $stable(digit_carry_flag) &&
      (working_reg == ($past(working_reg) & $past(instr_reg.literal))))
    else $error("literal AND result or carries wrong");

  chk_file_add_carry: assert property (
    @(posedge clk) disable iff (rst)
    (commit && is_add_file) |=>
      carry_flag == 1'(({1'b0, $past(working_reg)} + {1'b0, $past(operand_reg)}) >> 8))
    else $error("file add carry wrong");

  chk_file_and_zero: assert property (
    @(posedge clk) disable iff (rst)
    (commit && is_and_file && !sw_wr_flags) |=>
      (zero_flag == (($past(working_reg) & $past(operand_reg)) == 8'h00)) &&
      $stable(carry_flag))
    else $error("file AND flags wrong");

  chk_dest_route: assert property (
    @(posedge clk) disable iff (rst)
    (commit && (is_add_file || is_and_file)) |->
      (file_req.wr_en == instr_reg.dest_file))
    else $error("result went to the wrong destination");

  chk_bit_clear: assert property (
    @(posedge clk) disable iff (rst)
    (commit && is_bit_clr) |->
      file_req.wr_en && !file_req.wr_data[instr_reg.bit_idx] &&
      ((file_req.wr_data | bit_mask) == (operand_reg | bit_mask)))
    else $error("bit clear altered the wrong bits");

  chk_bit_set_flags: assert property (
    @(posedge clk) disable iff (rst)
    (commit && is_bit_set && !sw_wr_flags) |->
      file_req.wr_data == (operand_reg | bit_mask) ##1 $stable(flags_reg))
    else $error("bit set result or flags wrong");

  chk_cycle_len: assert property (
    @(posedge clk) disable iff (rst)
    take |=> (!instr_done && !instr_ready) [*3] ##1 instr_done)
    else $error("instruction did not take four periods");

  chk_port_pins: assert property (
    @(posedge clk) disable iff (rst)
    (in_fetch && !is_literal && at_port) |=> operand_reg == $past(pins_sync_reg))
    else $error("port operand not taken from the pins");

  chk_zero_flag: assert property (
    @(posedge clk) disable iff (rst)
    (commit && (is_add || is_and)) |=> zero_flag == ($past(result_reg) == 8'h00))
    else $error("zero flag does not match the result");

  // Additions own the carry flags in their commit period, so no bus write can interfere.
  chk_add_digit_carry: assert property (
    @(posedge clk) disable iff (rst)
    (commit && is_add) |=>
      digit_carry_flag ==
        1'(({1'b0, $past(working_reg[3:0])} + {1'b0, $past(operand_reg[3:0])}) >> 4))
    else $error("digit carry does not match the low nibble sum");

  chk_retired_count: assert property (
    @(posedge clk) disable iff (rst)
    commit |=> retired_reg == 8'($past(retired_reg) + 8'h01))
    else $error("retired count did not advance on commit");

  cov_add_carry: cover property (
    @(posedge clk) disable iff (rst) commit && is_add && alu_flags_reg[FLAG_CARRY]);
  cov_back_to_back: cover property (
    @(posedge clk) disable iff (rst) take ##4 take);
  cov_port_set: cover property (
    @(posedge clk) disable iff (rst) commit && is_bit_set && at_port);
  cov_to_file: cover property (
    @(posedge clk) disable iff (rst) commit && is_and_file && instr_reg.dest_file);
  cov_port_add: cover property (
    @(posedge clk) disable iff (rst) commit && is_add_file && at_port && add_carry);

endmodule
`default_nettype wire

/* File: pkg/byte_alu_pkg.sv */
// Constants, operation codes and carrier types for the byte ALU and bit operation block.
// Functional notes
// - Literal add: working register plus 8-bit literal into working; C, DC, Z updated.
// - Literal AND: working AND literal into working; only Z updated.
// - File add: working plus addressed file register (0-127); C, DC, Z updated.
// - File AND: working AND addressed file register; only Z updated, carries kept.
// - File add/AND: destination 0 writes working, 1 writes the file register.
// - Bit clear: selected bit (0-7) of file register forced low; flags untouched.
// - Bit set: selected bit (0-7) of file register forced high; flags untouched.
// - Every operation finishes in one instruction cycle of four oscillator periods.
// - Read-modify-write on the I/O port register reads pin levels, not the latch.
package byte_alu_pkg;

  localparam int unsigned DATA_W        = 8;
  localparam int unsigned FILE_ADDR_W   = 7;
  localparam int unsigned BIT_IDX_W     = 3;
  localparam int unsigned BUS_ADDR_W    = 4;
  localparam int unsigned OSC_PER_INSTR = 4;

  // Phases of one instruction cycle.
  localparam logic [1:0] PH_READ   = 2'h0;
  localparam logic [1:0] PH_FETCH  = 2'h1;
  localparam logic [1:0] PH_EXEC   = 2'h2;
  localparam logic [1:0] PH_COMMIT = 2'h3;

  // Register offsets on the software port.
  localparam logic [3:0] REG_WORKING = 4'h0;
  localparam logic [3:0] REG_FLAGS   = 4'h1;
  localparam logic [3:0] REG_RETIRED = 4'h2;

  // Flag positions inside the flags register.
  localparam int unsigned FLAG_CARRY = 0;
  localparam int unsigned FLAG_DIGIT = 1;
  localparam int unsigned FLAG_ZERO  = 2;

  localparam logic [7:0] WORKING_RESET = 8'h00;
  localparam logic [2:0] FLAGS_RESET   = 3'h0;
  localparam logic [7:0] RETIRED_RESET = 8'h00;

  // File address of the I/O port register whose reads come from the pins.
  localparam logic [6:0] PORT_FILE_ADDR = 7'h06;

  typedef enum logic [2:0] {
    OP_ADD_LITERAL_TO_WORKING,
    OP_AND_LITERAL_WITH_WORKING,
    OP_ADD_WORKING_TO_FILE,
    OP_AND_WORKING_WITH_FILE,
    OP_BIT_CLEAR_IN_FILE,
    OP_BIT_SET_IN_FILE
  } op_t;

  typedef struct packed {
    op_t        op;
    logic [6:0] file_addr;
    logic [2:0] bit_idx;
    logic [7:0] literal;
    logic       dest_file;
  } instr_t;

  typedef struct packed {
    logic       rd_en;
    logic       wr_en;
    logic [6:0] addr;
    logic [7:0] wr_data;
  } file_req_t;

endpackage

/* File: rtl/byte_adder.sv */
// Byte adder that also reports the carry out of the low nibble.
`timescale 1ns/1ps
`default_nettype none
module byte_adder
  import byte_alu_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W
) (
  // Operands
  input  wire logic [WIDTH-1:0] a,
  input  wire logic [WIDTH-1:0] b,
  // Results
  output logic      [WIDTH-1:0] sum,
  output logic                  carry_out,
  output logic                  nibble_carry
);

  initial begin
    if (WIDTH < 5) begin
      $error("byte_adder needs at least five bits");
    end
  end

  logic [WIDTH:0] full_sum;
  logic [4:0]     low_sum;

  assign full_sum     = {1'b0, a} + {1'b0, b};
  assign low_sum      = {1'b0, a[3:0]} + {1'b0, b[3:0]};
  assign sum          = full_sum[WIDTH-1:0];
  assign carry_out    = full_sum[WIDTH];
  assign nibble_carry = low_sum[4];

endmodule
`default_nettype wire

/* File: rtl/phase_counter.sv */
// Counts the oscillator periods of one instruction cycle.
`timescale 1ns/1ps
`default_nettype none
module phase_counter
  import byte_alu_pkg::*;
#(
  parameter int unsigned PHASES = OSC_PER_INSTR
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Control
  input  wire logic                      start,
  // State
  output logic                           active,
  output logic [$clog2(PHASES)-1:0]      phase,
  output logic                           last
);

  initial begin
    if (PHASES != OSC_PER_INSTR) begin
      $error("phase_counter must count four periods per instruction");
    end
  end

  localparam int unsigned PW = $clog2(PHASES);
  localparam logic [PW-1:0] LAST_PHASE = PW'(PHASES - 1);

  logic          active_reg;
  logic          active_next;
  logic [PW-1:0] phase_reg;
  logic [PW-1:0] phase_next;

  assign last        = active_reg && (phase_reg == LAST_PHASE);
  assign active_next = start || (active_reg && !last);
  assign phase_next  = start ? '0 : (active_reg && !last) ? phase_reg + 1'b1 : '0;
  assign active      = active_reg;
  assign phase       = phase_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_reg <= 1'b0;
      phase_reg  <= '0;
    end else begin
      active_reg <= active_next;
      phase_reg  <= phase_next;
    end
  end

endmodule
`default_nettype wire

/* File: verif/byte_alu_bit_ops_tb.sv */
// Self-checking testbench for the byte ALU and bit operation block.
`timescale 1ns/1ps
`default_nettype none
module byte_alu_bit_ops_tb
  import byte_alu_pkg::*;
();
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic       bus_wr = 1'b0;
  logic       bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic       instr_valid = 1'b0;
  instr_t     instr = '0;
  logic       instr_ready;
  logic       instr_done;
  file_req_t  file_req;
  logic [7:0] file_rd_data = 8'h00;
  logic [7:0] port_pins = 8'h5A;
  logic       carry_flag;
  logic       digit_carry_flag;
  logic       zero_flag;
  int         error_cnt = 0;
  int         check_count = 0;
  int         rc = 0;
  int         i;
  int         k;
  int         last;
  logic [7:0] wm = 8'h00;
  logic [2:0] fm = 3'h0;
  logic [7:0] wv [4] = '{8'h0F, 8'hFF, 8'h00, 8'h88};
  logic [7:0] lv [4] = '{8'h01, 8'h01, 8'hFF, 8'h88};

  always #10 clk = ~clk;

  byte_alu_bit_ops dut_u (
    .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .instr_done(instr_done), .file_req(file_req),
    .file_rd_data(file_rd_data), .port_pins(port_pins), .carry_flag(carry_flag),
    .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    if (a == REG_WORKING)
      wm = d;
    if (a == REG_FLAGS)
      fm = d[2:0];
  endtask

  task automatic bus_read(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(negedge clk);
    check(bus_rdata, exp);
  endtask

  // Issues one instruction, answers its file read and checks the schedule and results.
  task automatic exec(input op_t op, input logic [6:0] fa, input logic [2:0] bi,
                      input logic [7:0] lit, input logic d, input logic [7:0] fd);
    logic [7:0] src;
    logic [7:0] b;
    logic [7:0] r;
    logic [8:0] s;
    logic [4:0] nib;
    logic       to_file;
    logic       tk;
    int         n;
    src = (fa == PORT_FILE_ADDR) ? port_pins : fd;
    b = (op < OP_ADD_WORKING_TO_FILE) ? lit : src;
    s = {1'b0, wm} + {1'b0, b};
    nib = {1'b0, wm[3:0]} + {1'b0, b[3:0]};
    case (op)
      OP_ADD_LITERAL_TO_WORKING, OP_ADD_WORKING_TO_FILE: r = s[7:0];
      OP_AND_LITERAL_WITH_WORKING, OP_AND_WORKING_WITH_FILE: r = wm & b;
      OP_BIT_CLEAR_IN_FILE: r = src & ~(8'h01 << bi);
      default: r = src | (8'h01 << bi);
    endcase
    to_file = (op > OP_AND_WORKING_WITH_FILE) || (op > OP_AND_LITERAL_WITH_WORKING && d);
    @(posedge clk);
    instr_valid  <= 1'b1;
    instr        <= '{op, fa, bi, lit, d};
    file_rd_data <= fd;
    n = 0;
    do begin
      @(negedge clk);
      tk = instr_ready;
      @(posedge clk);
      n++;
    end while (tk !== 1'b1 && n < 20);
    instr_valid <= 1'b0;
    @(negedge clk);
    check({7'h00, file_req.rd_en}, {7'h00, op > OP_AND_LITERAL_WITH_WORKING});
    check({7'h00, instr_ready}, 8'h00);
    if (op > OP_AND_LITERAL_WITH_WORKING)
      check({1'b0, file_req.addr}, {1'b0, fa});
    n = 1;
    while (instr_done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check(8'(n), 8'h04);
    check({7'h00, instr_ready}, 8'h01);
    check({7'h00, file_req.wr_en}, {7'h00, to_file});
    if (to_file)
      check(file_req.wr_data, r);
    if (op == OP_ADD_LITERAL_TO_WORKING || op == OP_ADD_WORKING_TO_FILE)
      fm = {r == 8'h00, nib[4], s[8]};
    else if (op < OP_BIT_CLEAR_IN_FILE)
      fm[2] = (r == 8'h00);
    if (!to_file && op < OP_BIT_CLEAR_IN_FILE)
      wm = r;
    rc++;
    @(posedge clk);
    file_rd_data <= ~fd;
    @(negedge clk);
    check({5'h00, zero_flag, digit_carry_flag, carry_flag}, {5'h00, fm});
    bus_read(REG_WORKING, wm);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus_read(REG_WORKING, WORKING_RESET);
    bus_read(REG_FLAGS, {5'h00, FLAGS_RESET});
    bus_read(REG_RETIRED, RETIRED_RESET);
    bus_read(4'hF, 8'h00);
    bus_write(REG_FLAGS, 8'hFF);
    bus_read(REG_FLAGS, 8'h07);
    bus_write(REG_RETIRED, 8'h55);
    bus_read(REG_RETIRED, 8'h00);
    bus_write(REG_FLAGS, 8'h00);
    for (i = 0; i < 4; i++) begin
      bus_write(REG_WORKING, wv[i]);
      exec(OP_ADD_LITERAL_TO_WORKING, 7'h00, 3'h0, lv[i], 1'b0, 8'h00);
    end
    bus_write(REG_FLAGS, 8'h03);
    bus_write(REG_WORKING, 8'hF0);
    exec(OP_AND_LITERAL_WITH_WORKING, 7'h00, 3'h0, 8'h0F, 1'b0, 8'h00);
    exec(OP_AND_LITERAL_WITH_WORKING, 7'h00, 3'h0, 8'hFF, 1'b0, 8'h00);
    bus_write(REG_WORKING, 8'h01);
    exec(OP_ADD_WORKING_TO_FILE, 7'h7F, 3'h0, 8'h00, 1'b1, 8'hFF);
    bus_write(REG_WORKING, 8'h0F);
    exec(OP_ADD_WORKING_TO_FILE, 7'h00, 3'h0, 8'h00, 1'b0, 8'h01);
    bus_write(REG_FLAGS, 8'h03);
    bus_write(REG_WORKING, 8'h3C);
    exec(OP_AND_WORKING_WITH_FILE, 7'h7F, 3'h0, 8'h00, 1'b1, 8'hC3);
    exec(OP_AND_WORKING_WITH_FILE, 7'h01, 3'h0, 8'h00, 1'b0, 8'h3C);
    bus_write(REG_FLAGS, 8'h05);
    for (i = 0; i < 8; i++) begin
      exec(OP_BIT_CLEAR_IN_FILE, 7'h20 + 7'(i), 3'(i), 8'h00, 1'b0, 8'hFF);
      exec(OP_BIT_SET_IN_FILE, 7'h40, 3'(i), 8'h00, 1'b1, 8'h00);
    end
    @(posedge clk);
    port_pins <= 8'h3C;
    bus_write(REG_WORKING, 8'hFF);
    exec(OP_AND_WORKING_WITH_FILE, PORT_FILE_ADDR, 3'h0, 8'h00, 1'b1, 8'hC3);
    exec(OP_BIT_SET_IN_FILE, PORT_FILE_ADDR, 3'h0, 8'h00, 1'b0, 8'h00);
    exec(OP_ADD_WORKING_TO_FILE, PORT_FILE_ADDR, 3'h0, 8'h00, 1'b0, 8'h00);
    // Back-to-back literal adds: valid stays high until the third done, so a take lands in each of the first three done cycles.
    bus_write(REG_FLAGS, 8'h00);
    bus_write(REG_WORKING, 8'h00);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr       <= '{OP_ADD_LITERAL_TO_WORKING, 7'h00, 3'h0, 8'h01, 1'b0};
    k = 0;
    last = 0;
    for (i = 0; i < 40 && k < 4; i++) begin
      @(negedge clk);
      if (instr_done === 1'b1) begin
        if (k > 0)
          check(8'(i - last), 8'h04);
        last = i;
        k++;
        if (k == 3) begin
          @(posedge clk);
          instr_valid <= 1'b0;
        end
      end
    end
    check(8'(k), 8'h04);
    rc = rc + 4;
    repeat (2) @(posedge clk);
    bus_read(REG_WORKING, 8'h04);
    bus_read(REG_FLAGS, 8'h00);
    bus_read(REG_RETIRED, 8'(rc));
    stop_test();
  end
endmodule
`default_nettype wire
